// ### iln_regs.svh
// register offsets, field positions, codes and counts for the lane framer
// assumes a 32-bit ahb-lite slave port and a 67-bit lane word
`ifndef ILN_REGS_SVH
`define ILN_REGS_SVH
`define ILN_CTRL_OFS    32'h0000_0000
`define ILN_STAT_OFS    32'h0000_0004
`define ILN_CTRL_EN     13
`define ILN_CTRL_LANE   14
`define ILN_CTRL_LINK   15
`define ILN_ST_WLOCK    0
`define ILN_ST_FLOCK    1
`define ILN_ST_SYNC     2
`define ILN_ST_SCR      3
`define ILN_ST_CRC      4
`define ILN_ST_LANE     5
`define ILN_ST_LINK     6
`define ILN_MFLEN_RST   13'h0800
`define ILN_MFLEN_MIN   13'h0005
`define ILN_HDR_DATA    2'h1
`define ILN_HDR_CTL     2'h2
`define ILN_SYNC_WORD   64'h78F6_78F6_78F6_78F6
`define ILN_TYPE_SCR    6'h0A
`define ILN_TYPE_SKIP   6'h07
`define ILN_TYPE_DIAG   6'h19
`define ILN_CRC_POLY    32'h1EDC_6F41
`define ILN_CRC_INIT    32'hFFFF_FFFF
`define ILN_WGOOD_N     7'h40
`define ILN_WWIN_N      7'h40
`define ILN_WBAD_N      5'h10
`define ILN_FLOCK_N     3'h4
`define ILN_SYNC_BAD_N  3'h4
`define ILN_SCR_BAD_N   2'h3
`define ILN_RD_MAX      9'h060
`endif

// ### iln_pkg.sv
// types shared by the lane framer
// assumes nothing beyond a standard elaborator
`default_nettype none
package iln_pkg;
	typedef enum logic {FS_HUNT, FS_LOCK} iln_fs_t;
	typedef struct packed {
		logic [12:0] mflen;
		logic        tx_en;
		logic        tx_lane;
		logic        tx_link;
		logic        e_sync;
		logic        e_scr;
		logic        e_crc;
		logic        hwr;
		logic        hctrl;
		logic        hstat;
		logic [31:0] hrdata;
		logic        hrdy;
		logic        hresp;
		logic [12:0] tpos;
		logic [57:0] tlfsr;
		logic [31:0] tcrc;
		logic [8:0]  rd;
		logic [66:0] tword;
		logic        twv;
		logic        trdy;
		logic [6:0]  wgood;
		logic [6:0]  wwin;
		logic [4:0]  wbad;
		logic        wlock;
		iln_fs_t     fs;
		logic [12:0] rpos;
		logic [2:0]  scnt;
		logic [2:0]  sbad;
		logic [1:0]  mbad;
		logic [57:0] rlfsr;
		logic [31:0] rcrc;
		logic [63:0] rdata;
		logic        rdv;
		logic        rlane;
		logic        rlink;
		logic        crcerr;
		logic        rrdy;
	} iln_st_t;
endpackage
`default_nettype wire

// ### iln_lane_framer.sv
// one interlaken lane: metaframe generator and frame synchronizer
// assumes lane words arrive and leave on CLK; ahb-lite for registers
// Behaviour
// [RULE1] find boundaries, classify four control word types
// [RULE2] frame lock after four consecutive sync words
// [RULE3] lose lock: four bad syncs, three state mismatches
// [RULE4] frame lock status output to user
// [RULE5] invert words to keep disparity within 96
// [RULE6] bit 66 flags an inverted word
// [RULE7] receiver restores polarity from bit 66
// [RULE8] scrambler polynomial x^58 + x^39 + 1
// [RULE9] sync, state words and header unscrambled
// [RULE10] each lane seeds scrambler with own value
// [RULE11] descrambler loads from received state word
// [RULE12] ready, frame lock, crc error outputs
// [RULE13] status register: locks, sync, scrambler, crc
// [RULE14] absorb 100 ppm by skip deletion, any length
// [RULE15] mandatory skip right after scrambler state word
// [RULE16] extra skips when transmit fill runs low
// [RULE17] drop received skip words silently
// [RULE18] crc-32 per metaframe into diagnostic word
// [RULE19] check crc, take lane bit 33, link 32
// [RULE20] word lock 64 good, drop 16 bad in 64
// [RULE21] metaframe length 5..8191, same both ends
// [RULE22] after loss, count sync words from zero
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`include "iln_regs.svh"
`default_nettype none
module iln_lane_framer #(
	// value is arbitrary, only needs to differ per lane and be nonzero
	parameter logic [57:0] SCR_SEED = 58'h2A5_5A5A_1234_5678
) (
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic [63:0] TX_DATA,
	input  wire logic        TX_DVALID,
	input  wire logic        TX_FILL_LOW,
	output logic             TX_DREADY,
	output logic      [66:0] TX_WORD,
	output logic             TX_WVALID,
	input  wire logic [66:0] RX_WORD,
	input  wire logic        RX_WVALID,
	output logic      [63:0] RX_DATA,
	output logic             RX_DVALID,
	output logic             RX_READY,
	output logic             RX_WLOCK,
	output logic             RX_FLOCK,
	output logic             RX_CRC_ERR,
	output logic             RX_LANE_ST,
	output logic             RX_LINK_ST
);
	iln_pkg::iln_st_t q;
	iln_pkg::iln_st_t n;

	// additive generator: 64 steps per scrambled word
	function automatic logic [121:0] scr(input logic [57:0] s,
		input logic [63:0] d);
		logic [57:0] t;
		logic [63:0] o;
		t = s;
		o = d;
		for (int i = 63; i >= 0; i--) begin
			o[i] = d[i] ^ t[57] ^ t[38]; // [RULE8]
			t = {t[56:0], t[57] ^ t[38]};
		end
		return {t, o};
	endfunction

	function automatic logic [31:0] crc(input logic [31:0] c,
		input logic [63:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 63; i >= 0; i--)
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `ILN_CRC_POLY : 32'h0);
		return r;
	endfunction

	always_comb begin
		logic [63:0]  raw;
		logic [63:0]  sp;
		logic [63:0]  p;
		logic [63:0]  dw;
		logic [63:0]  dg;
		logic [121:0] sv;
		logic [121:0] rv;
		logic [1:0]   hdr;
		logic [1:0]   rh;
		logic [6:0]   ones;
		logic [6:0]   ones7;
		logic [8:0]   wd;
		logic [12:0]  last;
		logic [12:0]  nxt;
		logic         inv;
		logic         ctl;
		logic         lose;
		logic         ok;
		logic         adr;
		logic         bypass;
		logic         is_sync;
		raw = 64'h0;
		sp = 64'h0;
		dg = 64'h0;
		sv = '0;
		hdr = `ILN_HDR_CTL;
		ones = 7'h00;
		ones7 = 7'h00;
		wd = 9'h000;
		inv = 1'b0;
		bypass = 1'b0;
		lose = 1'b0;
		p = 64'h0;
		dw = 64'h0;
		rv = '0;
		rh = 2'h0;
		nxt = 13'h0000;
		ctl = 1'b0;
		ok = 1'b0;
		adr = 1'b0;
		is_sync = 1'b0;
		n = q;
		n.crcerr = 1'b0;
		n.rdv = 1'b0;
		last = q.mflen - 13'h0001;

		// data phase of a write; clears first so a same-cycle event wins
		if (q.hwr && q.hctrl) begin
			n.mflen = (HWDATA[12:0] < `ILN_MFLEN_MIN) ?
				`ILN_MFLEN_MIN : HWDATA[12:0]; // [RULE21]
			n.tx_en = HWDATA[`ILN_CTRL_EN];
			n.tx_lane = HWDATA[`ILN_CTRL_LANE];
			n.tx_link = HWDATA[`ILN_CTRL_LINK];
		end
		if (q.hwr && q.hstat) begin
			n.e_sync = q.e_sync & ~HWDATA[`ILN_ST_SYNC];
			n.e_scr = q.e_scr & ~HWDATA[`ILN_ST_SCR];
			n.e_crc = q.e_crc & ~HWDATA[`ILN_ST_CRC];
		end

		// transmit: one word per clock while enabled
		nxt = (q.tpos >= last) ? 13'h0000 : q.tpos + 13'h0001;
		n.twv = q.tx_en;
		n.trdy = 1'b0;
		if (!q.tx_en) begin
			n.tpos = 13'h0000;
		end else begin
			n.tpos = nxt;
			// a fill-low slot becomes a skip instead of data
			n.trdy = (nxt >= 13'h0003) && (nxt < last) &&
				!TX_FILL_LOW; // [RULE16]
			if (q.tpos == 13'h0000) begin
				raw = `ILN_SYNC_WORD;
			end else if (q.tpos == 13'h0001) begin
				raw = {`ILN_TYPE_SCR, q.tlfsr};
			end else if (q.tpos >= last) begin
				dg = {`ILN_TYPE_DIAG, 24'h0, q.tx_lane, q.tx_link, 32'h0};
				raw = {dg[63:32], crc(q.tcrc, dg)}; // [RULE18]
			end else if (q.trdy && TX_DVALID) begin
				raw = TX_DATA;
				hdr = `ILN_HDR_DATA;
			end else begin
				// slot 2 always lands here: skip after state word
				raw = {`ILN_TYPE_SKIP, 58'h0}; // [RULE15]
			end
			bypass = q.tpos < 13'h0002; // [RULE9]
			sv = scr(q.tlfsr, raw);
			sp = bypass ? raw : sv[63:0];
			n.tlfsr = bypass ? q.tlfsr : sv[121:64];
			n.tcrc = crc((q.tpos == 13'h0000) ? `ILN_CRC_INIT : q.tcrc,
				raw);
			ones = 7'($countones({hdr, sp}));
			wd = {1'b0, ones, 1'b0} - 9'h042;
			// invert when the word would push further the same way
			inv = (q.rd != 9'h000) && (wd != 9'h000) &&
				(q.rd[8] == wd[8]); // [RULE5]
			n.tword = {inv, hdr, inv ? ~sp : sp}; // [RULE6]
			ones7 = 7'($countones(n.tword));
			n.rd = q.rd + {1'b0, ones7, 1'b0} - 9'h043;
		end

		// receive
		rh = RX_WORD[65:64];
		p = RX_WORD[66] ? ~RX_WORD[63:0] : RX_WORD[63:0]; // [RULE7]
		ctl = rh == `ILN_HDR_CTL;
		is_sync = ctl && (p == `ILN_SYNC_WORD);
		rv = scr(q.rlfsr, p);
		dw = rv[63:0];
		ok = ^rh;
		if (RX_WVALID) begin
			if (!q.wlock) begin
				n.wgood = ok ? q.wgood + 7'h01 : 7'h00;
				if (ok && q.wgood == `ILN_WGOOD_N - 7'h01) begin
					n.wlock = 1'b1; // [RULE20]
					n.wwin = 7'h00;
					n.wbad = 5'h00;
				end
			end else begin
				n.wwin = q.wwin + 7'h01;
				n.wbad = q.wbad + {4'h0, !ok};
				if (!ok && q.wbad == `ILN_WBAD_N - 5'h01) begin
					n.wlock = 1'b0; // [RULE20]
					n.wgood = 7'h00;
				end else if (q.wwin == `ILN_WWIN_N - 7'h01) begin
					n.wwin = 7'h00;
					n.wbad = 5'h00;
				end
			end
			n.rpos = (q.rpos >= last) ? 13'h0000 : q.rpos + 13'h0001;
			if (q.rpos == 13'h0000) begin
				n.rcrc = crc(`ILN_CRC_INIT, p);
			end else if (q.rpos == 13'h0001) begin
				n.rlfsr = p[57:0]; // [RULE11]
				n.rcrc = crc(q.rcrc, p);
			end else begin
				n.rlfsr = rv[121:64];
				n.rcrc = crc(q.rcrc, dw);
			end
			case (q.fs)
			iln_pkg::FS_HUNT: begin
				if (is_sync) begin // [RULE1]
					n.scnt = (q.rpos == 13'h0000 && q.scnt != 3'h0) ?
						q.scnt + 3'h1 : 3'h1;
					n.rpos = 13'h0001;
					n.rcrc = crc(`ILN_CRC_INIT, p);
					if (q.rpos == 13'h0000 &&
						q.scnt == `ILN_FLOCK_N - 3'h1) begin
						n.fs = iln_pkg::FS_LOCK; // [RULE2]
						n.sbad = 3'h0;
						n.mbad = 2'h0;
					end
				end else if (q.rpos == 13'h0000) begin
					n.scnt = 3'h0;
				end
			end
			iln_pkg::FS_LOCK: begin
				if (q.rpos == 13'h0000) begin
					if (is_sync) begin
						n.sbad = 3'h0;
					end else begin
						n.sbad = q.sbad + 3'h1;
						n.e_sync = 1'b1; // [RULE13]
						lose = q.sbad == `ILN_SYNC_BAD_N - 3'h1; // [RULE3]
					end
				end else if (q.rpos == 13'h0001) begin
					if (ctl && p[63:58] == `ILN_TYPE_SCR &&
						p[57:0] == q.rlfsr) begin
						n.mbad = 2'h0;
					end else begin
						n.mbad = q.mbad + 2'h1;
						n.e_scr = 1'b1; // [RULE13]
						lose = q.mbad == `ILN_SCR_BAD_N - 2'h1; // [RULE3]
					end
				end else if (ctl && dw[63:58] == `ILN_TYPE_DIAG) begin
					dg = {dw[63:32], 32'h0};
					n.rlane = dw[33]; // [RULE19]
					n.rlink = dw[32];
					if (crc(q.rcrc, dg) != dw[31:0]) begin
						n.crcerr = 1'b1; // [RULE19]
						n.e_crc = 1'b1;
					end
				end else if (rh == `ILN_HDR_DATA) begin
					// a broken header is neither control nor user data
					n.rdata = dw;
					n.rdv = 1'b1;
				end
				// skips fall through unflagged; that slack covers ppm
				// drift in place of a receive buffer [RULE17] [RULE14]
				if (lose) begin
					n.fs = iln_pkg::FS_HUNT;
					n.scnt = 3'h0; // [RULE22]
				end
			end
			default: n.fs = iln_pkg::FS_HUNT;
			endcase
		end
		if (!n.wlock) begin
			n.fs = iln_pkg::FS_HUNT;
			n.scnt = 3'h0; // [RULE22]
		end
		n.rrdy = n.wlock && n.fs == iln_pkg::FS_LOCK; // [RULE12]

		// address phase; read mux sees the write just applied
		adr = HSEL && HTRANS[1] && HREADY;
		n.hwr = adr && HWRITE;
		n.hctrl = HADDR == `ILN_CTRL_OFS;
		n.hstat = HADDR == `ILN_STAT_OFS;
		n.hrdata = 32'h0;
		if (adr && !HWRITE && n.hctrl)
			n.hrdata = {16'h0, n.tx_link, n.tx_lane, n.tx_en, n.mflen};
		if (adr && !HWRITE && n.hstat)
			n.hrdata = {25'h0, n.rlink, n.rlane, n.e_crc, n.e_scr,
				n.e_sync, n.fs == iln_pkg::FS_LOCK, n.wlock}; // [RULE13]
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			q <= '0;
			q.mflen <= `ILN_MFLEN_RST;
			q.hrdy <= 1'b1;
			q.tlfsr <= SCR_SEED; // [RULE10]
		end else begin
			q <= n;
		end
	end

	assign HRDATA = q.hrdata;
	assign HREADYOUT = q.hrdy;
	assign HRESP = q.hresp;
	assign TX_DREADY = q.trdy;
	assign TX_WORD = q.tword;
	assign TX_WVALID = q.twv;
	assign RX_DATA = q.rdata;
	assign RX_DVALID = q.rdv;
	assign RX_READY = q.rrdy;
	assign RX_WLOCK = q.wlock;
	assign RX_FLOCK = q.fs == iln_pkg::FS_LOCK; // [RULE4]
	assign RX_CRC_ERR = q.crcerr;
	assign RX_LANE_ST = q.rlane;
	assign RX_LINK_ST = q.rlink;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	sequence s_ctrl_wr;
		HSEL && HTRANS[1] && HWRITE && HREADY && HADDR == `ILN_CTRL_OFS;
	endsequence

	a_rd_bound: assert property ( // [RULE5]
		$signed(q.rd) <= $signed(`ILN_RD_MAX) &&
		$signed(q.rd) >= -$signed(`ILN_RD_MAX))
		else $error("running disparity out of range");
	a_sync_clear: assert property ( // [RULE9]
		q.twv && q.tx_en && q.tpos == 13'h0001 |->
		(TX_WORD[66] ? ~TX_WORD[63:0] : TX_WORD[63:0]) == `ILN_SYNC_WORD)
		else $error("sync word left scrambled or wrong");
	a_skip_slot: assert property ( // [RULE15]
		q.twv && q.tx_en && q.tpos == 13'h0003 |->
		TX_WORD[65:64] == `ILN_HDR_CTL && !$past(q.trdy))
		else $error("slot after state word is not a skip");
	a_flock_gain: assert property ( // [RULE2]
		$rose(q.fs == iln_pkg::FS_LOCK) |-> $past(q.scnt) == 3'h3)
		else $error("frame lock without four sync words");
	a_flock_loss: assert property ( // [RULE3]
		$fell(q.fs == iln_pkg::FS_LOCK) |-> !q.wlock ||
		$past(q.sbad) == 3'h3 || $past(q.mbad) == 2'h2)
		else $error("frame lock dropped without cause");
	a_relock_zero: assert property ( // [RULE22]
		$fell(q.fs == iln_pkg::FS_LOCK) |-> q.scnt == 3'h0)
		else $error("sync count not restarted");
	a_wlock_gain: assert property ( // [RULE20]
		$rose(q.wlock) |-> $past(q.wgood) == 7'h3F)
		else $error("word lock before 64 good headers");
	a_skip_drop: assert property ( // [RULE17]
		RX_DVALID |-> $past(RX_WORD[65:64]) == `ILN_HDR_DATA &&
		$past(q.fs) == iln_pkg::FS_LOCK)
		else $error("control word passed to user");
	a_crc_sticky: assert property ( // [RULE13]
		RX_CRC_ERR |-> q.e_crc ##1 (q.e_crc || $past(q.hwr)))
		else $error("crc error not recorded");
	a_len_write: assert property ( // [RULE21]
		s_ctrl_wr ##1 (HWDATA[12:0] >= `ILN_MFLEN_MIN) |=>
		q.mflen == $past(HWDATA[12:0]))
		else $error("metaframe length not written");
	a_fill_skip: assert property ( // [RULE16]
		TX_FILL_LOW |=> !TX_DREADY)
		else $error("data slot granted while fill is low");
endmodule // iln_lane_framer
`default_nettype wire

// ### iln_far_lane.sv
// far-end lane model: the framer's own transmit words come back as rx
// assumes one clock; fault picks which kind of word gets damaged
`include "iln_regs.svh"
`default_nettype none
module iln_far_lane #(
	parameter int FLEN = 8
) (
	input  wire logic        clk,
	input  wire logic [66:0] tx_word,
	input  wire logic        tx_valid,
	input  wire logic [2:0]  fault,
	output logic      [66:0] rx_word,
	output logic             rx_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] p;
	logic [66:0] w;
	logic        c;
	int          k = 0;
	initial begin
		rx_word = 67'h0;
		rx_valid = 1'b0;
	end
	// loopback keeps both ends on the same frame length
	always @(posedge clk) begin
		p = tx_word[66] ? ~tx_word[63:0] : tx_word[63:0];
		w = tx_word;
		c = tx_word[65:64] == `ILN_HDR_CTL;
		// diag is scrambled, so find it by its place after sync
		k = (c && p == `ILN_SYNC_WORD) ? 0 : k + 1;
		case (fault)
			3'h1: if (p == `ILN_SYNC_WORD) w[0] = ~w[0];
			3'h2: if (c && p[63:58] == `ILN_TYPE_SCR) w[0] = ~w[0];
			3'h3: if (c && k == FLEN - 1) w[0] = ~w[0];
			3'h4: w[65:64] = 2'h0;
			default: ;
		endcase
		rx_valid <= tx_valid;
		// an idle line must not keep showing the last word
		rx_word <= tx_valid ? w : ~rx_word;
	end
endmodule // iln_far_lane
`default_nettype wire

// ### test_interlaken_lane_framing.sv
// self-checking bench: framer looped back through the far-lane model
// assumes zero-wait ahb answers and a frame length of eight words
`include "iln_regs.svh"
`default_nettype none
module test_interlaken_lane_framing;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int L = 8;
	localparam int FL[3] = '{1, 2, 4};
	localparam int LO[3] = '{3 * L - 1, 2 * L - 1, 15};
	// fixed 64-word windows: up to 15 bad words may fall before a restart
	localparam int HI[3] = '{5 * L, 4 * L, 34};
	logic        CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic        HSEL = 1'b0;
	logic        HWRITE = 1'b0;
	logic        TX_DVALID = 1'b0;
	logic        TX_FILL_LOW = 1'b0;
	logic [1:0]  HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0;
	logic [31:0] HWDATA = 32'h0;
	logic [63:0] TX_DATA = 64'h0;
	logic [2:0]  fault = 3'h0;
	logic        feed = 1'b0;
	logic [31:0] HRDATA, r, tc, x;
	logic [57:0] ls;
	logic        HREADYOUT, HRESP, TX_DREADY, TX_WVALID, RX_WVALID;
	logic [66:0] TX_WORD, RX_WORD;
	logic [63:0] RX_DATA, p, e, d;
	logic        RX_DVALID, RX_READY, RX_WLOCK, RX_FLOCK;
	logic        RX_CRC_ERR, RX_LANE_ST, RX_LINK_ST;
	logic [63:0] sent[$];
	int          mismatches = 0;
	int          cmp_count = 0;
	int          rd = 0, slot = 0, crc_n = 0, dv_n = 0, n, i;

	always #50 CLK = ~CLK;

	iln_lane_framer dut (
		.CLK        (CLK),
		.RST_B      (RST_B),
		.HSEL       (HSEL),
		.HADDR      (HADDR),
		.HTRANS     (HTRANS),
		.HWRITE     (HWRITE),
		.HSIZE      (3'h2),
		.HWDATA     (HWDATA),
		.HREADY     (HREADYOUT),
		.HRDATA     (HRDATA),
		.HREADYOUT  (HREADYOUT),
		.HRESP      (HRESP),
		.TX_DATA    (TX_DATA),
		.TX_DVALID  (TX_DVALID),
		.TX_FILL_LOW(TX_FILL_LOW),
		.TX_DREADY  (TX_DREADY),
		.TX_WORD    (TX_WORD),
		.TX_WVALID  (TX_WVALID),
		.RX_WORD    (RX_WORD),
		.RX_WVALID  (RX_WVALID),
		.RX_DATA    (RX_DATA),
		.RX_DVALID  (RX_DVALID),
		.RX_READY   (RX_READY),
		.RX_WLOCK   (RX_WLOCK),
		.RX_FLOCK   (RX_FLOCK),
		.RX_CRC_ERR (RX_CRC_ERR),
		.RX_LANE_ST (RX_LANE_ST),
		.RX_LINK_ST (RX_LINK_ST)
	);

	iln_far_lane #(.FLEN(L)) far (
		.clk     (CLK),
		.tx_word (TX_WORD),
		.tx_valid(TX_WVALID),
		.fault   (fault),
		.rx_word (RX_WORD),
		.rx_valid(RX_WVALID)
	);

	task automatic chk(input string nm, input logic [63:0] x, y);
		cmp_count++;
		if (y !== x) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, x, y);
		end
	endtask

	// additive x^58 + x^39 + 1 generator, msb first; gives {state, data}
	function automatic logic [121:0] unscr(input logic [57:0] s,
		input logic [63:0] v);
		logic b;
		for (int j = 63; j >= 0; j--) begin
			b = s[57] ^ s[38];
			v[j] = v[j] ^ b;
			s = {s[56:0], b};
		end
		return {s, v};
	endfunction

	function automatic logic [31:0] crc32(input logic [31:0] c,
		input logic [63:0] v);
		for (int j = 63; j >= 0; j--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ v[j]) ? `ILN_CRC_POLY : 32'h0);
		return c;
	endfunction

	task automatic test_done();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d);
		HSEL <= 1'b1;
		HADDR <= a;
		HWRITE <= w;
		HTRANS <= 2'h2;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask

	task automatic wt(input logic wl, input logic v);
		n = 0;
		while (n < 400 && (wl ? RX_WLOCK : RX_FLOCK) !== v) begin
			@(posedge CLK);
			n++;
		end
	endtask

	always @(posedge CLK) begin
		TX_DVALID <= feed && $urandom_range(3) != 0;
		TX_DATA <= {$urandom, $urandom};
		if (TX_DREADY === 1'b1 && TX_DVALID === 1'b1)
			sent.push_back(TX_DATA);
		if (RX_CRC_ERR === 1'b1)
			crc_n++;
		if (RX_DVALID === 1'b1) begin
			dv_n++;
			// nothing owed means data leaked out before lock
			e = sent.size() ? sent.pop_front() : ~RX_DATA;
			chk("rx_data", e, RX_DATA);
		end
		if (TX_WVALID === 1'b1) begin
			p = TX_WORD[66] ? ~TX_WORD[63:0] : TX_WORD[63:0];
			rd += 2 * $countones(TX_WORD) - 67;
			chk("disparity", 64'h1, rd >= -96 && rd <= 96);
			if (slot == 0) chk("sync", `ILN_SYNC_WORD, p);
			if (slot == 1) chk("state", `ILN_TYPE_SCR, p[63:58]);
			if (slot < 2)
				d = p;
			else
				{ls, d} = unscr(ls, p);
			if (slot == 1)
				ls = p[57:0];
			x = crc32(tc, {d[63:32], 32'h0});
			if (slot == 2) chk("skip", `ILN_TYPE_SKIP, d[63:58]);
			if (slot == L - 1) chk("diag", `ILN_TYPE_DIAG, d[63:58]);
			if (slot == L - 1) chk("diag_crc", x, d[31:0]);
			tc = crc32(slot ? tc : `ILN_CRC_INIT, d);
			slot = (slot + 1) % L;
		end else
			slot = 0;
	end

	initial begin
		repeat (6000) @(posedge CLK);
		mismatches++;
		test_done();
	end

	initial begin
		void'($urandom(69390));
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		ahb(1'b0, `ILN_CTRL_OFS, 32'h0);
		chk("ctrl_reset", 64'h800, r);
		ahb(1'b0, `ILN_STAT_OFS, 32'h0);
		chk("stat_reset", 64'h0, r);
		ahb(1'b1, 32'h8, 32'hFFFF_FFFF);
		ahb(1'b0, 32'h8, 32'h0);
		chk("unmapped", 64'h0, r);
		ahb(1'b1, `ILN_CTRL_OFS, 32'h3);
		ahb(1'b0, `ILN_CTRL_OFS, 32'h0);
		chk("len_min", 64'h5, r);
		ahb(1'b1, `ILN_CTRL_OFS, 32'h2008);
		wt(1'b1, 1'b1);
		chk("wlock_time", 64'h1, n >= 63);
		wt(1'b0, 1'b1);
		chk("flock", 64'h1, RX_FLOCK);
		chk("ready", 64'h1, RX_READY);
		ahb(1'b0, `ILN_STAT_OFS, 32'h0);
		chk("stat_lock", 64'h3, r);
		feed <= 1'b1;
		repeat (6 * L) @(posedge CLK);
		TX_FILL_LOW <= 1'b1;
		repeat (8) @(posedge CLK);
		i = dv_n;
		repeat (3 * L) @(posedge CLK);
		chk("fill_skip", i, dv_n);
		TX_FILL_LOW <= 1'b0;
		crc_n = 0;
		fault <= 3'h3;
		repeat (L) @(posedge CLK);
		fault <= 3'h0;
		repeat (2 * L) @(posedge CLK);
		chk("crc_err", 64'h1, crc_n);
		ahb(1'b0, `ILN_STAT_OFS, 32'h0);
		chk("stat_crc", 64'h1, r[4]);
		ahb(1'b1, `ILN_STAT_OFS, 32'h10);
		ahb(1'b0, `ILN_STAT_OFS, 32'h0);
		chk("crc_clear", 64'h0, r[4]);
		for (i = 1; i < 3; i++) begin
			ahb(1'b1, `ILN_CTRL_OFS, 32'h2008 | (i << 14));
			repeat (3 * L) @(posedge CLK);
			chk("lane_st", i & 1, RX_LANE_ST);
			chk("link_st", i >> 1, RX_LINK_ST);
			ahb(1'b0, `ILN_STAT_OFS, 32'h0);
			chk("stat_st", i, r[6:5]);
		end
		feed <= 1'b0;
		repeat (2 * L) @(posedge CLK);
		chk("drained", 64'h0, sent.size());
		for (int k = 0; k < 3; k++) begin
			fault <= 3'(FL[k]);
			wt(FL[k] == 4, 1'b0);
			chk("loss_time", 64'h1, n >= LO[k] && n <= HI[k]);
			fault <= 3'h0;
			ahb(1'b0, `ILN_STAT_OFS, 32'h0);
			if (k < 2) chk("stat_err", 64'h1, r[k + 2]);
			ahb(1'b1, `ILN_STAT_OFS, 32'h1C);
			wt(1'b1, 1'b1);
			wt(1'b0, 1'b1);
			if (k == 0) chk("relock_time", 64'h1, n >= 3 * L - 6);
			chk("relock", 64'h1, RX_READY);
		end
		feed <= 1'b1;
		repeat (4 * L) @(posedge CLK);
		feed <= 1'b0;
		repeat (2 * L) @(posedge CLK);
		chk("drained", 64'h0, sent.size());
		test_done();
	end
endmodule // test_interlaken_lane_framing
`default_nettype wire
